//--- mef_event_irq.sv
// Event flags, interrupt mask, tone status and equalizer routing
`timescale 1ns/1ps
module mef_event_irq #(
    parameter int BIT_CYC  = mef_pkg::MEF_BIT_CYC,
    parameter int WIN_BITS = mef_pkg::MEF_WIN_BITS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    // Modem data path events
    input  wire logic                  rx_byte_done,
    input  wire logic                  rx_parity_bad,
    input  wire logic                  rx_data_read,
    input  wire logic                  tx_buf_free,
    input  wire logic                  tx_data_load,
    // Detector inputs
    input  wire logic                  ring_timing_node,
    input  wire logic                  call_tone_present,
    input  wire logic                  carrier_present,
    input  wire logic                  answer_present,
    input  wire logic                  plain_mark_present,
    // Band selects and routing
    input  wire mef_pkg::mef_band_t    channel_band_select,
    output mef_pkg::mef_eq_route_t     eq_route,
    // Transmit mark fill and interrupt
    output logic                       tx_force_mark,
    output logic                       irq_b
);
    import mef_pkg::*;

    // =========================================================
    // Bit clock and service windows
    logic bit_tick;
    logic rx_expired;
    logic tx_expired;

    mef_bit_tick #(.DIV(BIT_CYC)) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (bit_tick)
    );

    mef_window #(.BITS(WIN_BITS)) u_rxwin (
        .clk      (clk),
        .rst_b    (rst_b),
        .bit_tick (bit_tick),
        .start    (rx_byte_done),
        .serviced (rx_data_read),
        .expired  (rx_expired)
    );

    mef_window #(.BITS(WIN_BITS)) u_txwin (
        .clk      (clk),
        .rst_b    (rst_b),
        .bit_tick (bit_tick),
        .start    (tx_buf_free),
        .serviced (tx_data_load),
        .expired  (tx_expired)
    );

    // =========================================================
    // State
    logic [7:0]  flags_ff;
    logic [7:0]  mask_ff;
    mef_status_t stat_ff;
    logic        rx_hold_ff;
    logic        tx_hold_ff;
    logic        unf_ff;
    logic        irq_ff;
    logic [7:0]  rdata_ff;

    logic [7:0]  nxt_flags;
    logic [7:0]  nxt_mask;
    mef_status_t nxt_stat;
    logic        nxt_rx_hold;
    logic        nxt_tx_hold;
    logic        nxt_unf;
    logic        nxt_irq;
    logic [7:0]  nxt_rdata;
    logic [7:0]  set_ev;
    logic [7:0]  base_flags;
    logic        flag_rd;

    // =========================================================
    // Next-state logic
    always_comb begin
        nxt_stat.ring               = ring_timing_node;
        nxt_stat.call_tone_present  = call_tone_present;
        nxt_stat.carrier            = carrier_present;
        nxt_stat.answer             = answer_present;
        nxt_stat.plain_mark_present = plain_mark_present;
        flag_rd = reg_rd && (reg_addr == MEF_FLAGS_ADDR);

        // Data-path flags stay blocked after a flag read until serviced
        nxt_rx_hold = rx_hold_ff;
        nxt_tx_hold = tx_hold_ff;
        if (flag_rd && (flags_ff[MEF_B_RXRDY] || flags_ff[MEF_B_OVF])) begin
            nxt_rx_hold = 1'b1;
        end
        if (rx_data_read) begin
            nxt_rx_hold = 1'b0;
        end
        if (flag_rd && (flags_ff[MEF_B_TXRDY] || flags_ff[MEF_B_UNF])) begin
            nxt_tx_hold = 1'b1;
        end
        if (tx_data_load) begin
            nxt_tx_hold = 1'b0;
        end

        set_ev = 8'h00;
        set_ev[MEF_B_PARITY] = rx_byte_done && rx_parity_bad;
        set_ev[MEF_B_RING]   = stat_ff.ring != nxt_stat.ring;
        set_ev[MEF_B_TONE]   = (stat_ff.call_tone_present !=
                                call_tone_present) ||
                               (stat_ff.carrier != carrier_present) ||
                               (stat_ff.answer != answer_present);
        set_ev[MEF_B_OVF]    = rx_expired && !rx_hold_ff;
        set_ev[MEF_B_RXRDY]  = rx_byte_done && !rx_hold_ff;
        set_ev[MEF_B_UNF]    = tx_expired && !tx_hold_ff;
        set_ev[MEF_B_TXRDY]  = tx_buf_free && !tx_hold_ff;
        set_ev[MEF_B_MARK]   = stat_ff.plain_mark_present !=
                               plain_mark_present;

        // Set wins over the read clear so no event is lost
        base_flags = flag_rd ? 8'h00 : flags_ff;
        nxt_flags  = base_flags | set_ev;
        if (rx_byte_done && !rx_parity_bad && !flag_rd) begin
            nxt_flags[MEF_B_PARITY] = 1'b0;
        end

        nxt_mask = mask_ff;
        if (reg_wr && (reg_addr == MEF_MASK_ADDR)) begin
            nxt_mask = reg_wdata;
        end

        // A flag set in the same cycle as its read is a fresh 0->1 edge
        nxt_irq = irq_ff;
        if (flag_rd) begin
            nxt_irq = 1'b0;
        end
        if (|(set_ev & ~base_flags & mask_ff)) begin
            nxt_irq = 1'b1;
        end

        // Mark fill persists until a new byte is loaded
        nxt_unf = unf_ff;
        if (tx_expired) begin
            nxt_unf = 1'b1;
        end
        if (tx_data_load) begin
            nxt_unf = 1'b0;
        end

        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                MEF_FLAGS_ADDR: nxt_rdata = flags_ff;
                MEF_MASK_ADDR:  nxt_rdata = mask_ff;
                MEF_TONES_ADDR: nxt_rdata = {1'b1, stat_ff.ring,
                                    stat_ff.call_tone_present,
                                    stat_ff.carrier, stat_ff.answer,
                                    2'b00, stat_ff.plain_mark_present};
                default:        nxt_rdata = 8'h00;
            endcase
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags_ff   <= MEF_FLAGS_RST;
            mask_ff    <= MEF_MASK_RST;
            stat_ff    <= '0;
            rx_hold_ff <= 1'b0;
            tx_hold_ff <= 1'b0;
            unf_ff     <= 1'b0;
            irq_ff     <= 1'b0;
            rdata_ff   <= 8'h00;
        end else begin
            flags_ff   <= nxt_flags;
            mask_ff    <= nxt_mask;
            stat_ff    <= nxt_stat;
            rx_hold_ff <= nxt_rx_hold;
            tx_hold_ff <= nxt_tx_hold;
            unf_ff     <= nxt_unf;
            irq_ff     <= nxt_irq;
            rdata_ff   <= nxt_rdata;
        end
    end

    // =========================================================
    // Equalizer routing: same band means no equalizer helps either path
    always_comb begin
        eq_route.bypass   = channel_band_select.tx_high ==
                            channel_band_select.rx_high;
        eq_route.tx_hi_eq = !eq_route.bypass &&
                            channel_band_select.tx_high;
        eq_route.tx_lo_eq = !eq_route.bypass &&
                            !channel_band_select.tx_high;
        eq_route.rx_hi_eq = !eq_route.bypass &&
                            channel_band_select.rx_high;
        eq_route.rx_lo_eq = !eq_route.bypass &&
                            !channel_band_select.rx_high;
    end

    assign reg_rdata     = rdata_ff;
    assign tx_force_mark = unf_ff;
    assign irq_b         = !irq_ff;

    // =========================================================
    // Checks
    a_irq_rise: assert property (@(posedge clk) disable iff (!rst_b)
        (|(set_ev & ~base_flags & mask_ff)) |=> !irq_b)
        else $error("masked flag edge did not raise interrupt");
    a_read_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (flag_rd && set_ev == 8'h00) |=> (flags_ff == 8'h00 && irq_b))
        else $error("flag read did not clear");
    a_parity_set: assert property (@(posedge clk) disable iff (!rst_b)
        (rx_byte_done && rx_parity_bad) |=> flags_ff[MEF_B_PARITY])
        else $error("parity flag missing");
    a_ring_chg: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(stat_ff.ring) |-> flags_ff[MEF_B_RING])
        else $error("ring change flag missing");
    a_tone_chg: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(stat_ff.carrier) |-> flags_ff[MEF_B_TONE])
        else $error("tone change flag missing");
    a_rx_ready: assert property (@(posedge clk) disable iff (!rst_b)
        (rx_byte_done && !rx_hold_ff) |=> flags_ff[MEF_B_RXRDY])
        else $error("receive ready missing");
    a_rx_ovf: assert property (@(posedge clk) disable iff (!rst_b)
        (rx_expired && !rx_hold_ff) |=> flags_ff[MEF_B_OVF])
        else $error("overflow flag missing");
    a_tx_unf: assert property (@(posedge clk) disable iff (!rst_b)
        tx_expired |=> (tx_force_mark && (tx_hold_ff ||
                        flags_ff[MEF_B_UNF])))
        else $error("underflow handling missing");
    a_mark_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (tx_force_mark && !tx_data_load) |=> tx_force_mark)
        else $error("mark fill dropped early");
    a_mask_gate: assert property (@(posedge clk) disable iff (!rst_b)
        (irq_b && (set_ev & ~base_flags & mask_ff) == 8'h00 &&
         !flag_rd) |=> irq_b)
        else $error("masked event raised interrupt");
    a_eq_bypass: assert property (@(posedge clk) disable iff (!rst_b)
        (channel_band_select.tx_high == channel_band_select.rx_high) |->
        (eq_route == 5'h01))
        else $error("equalizer used in bypass");

    c_irq:  cover property (@(posedge clk) disable iff (!rst_b) !irq_b);
    c_ovf:  cover property (@(posedge clk) disable iff (!rst_b)
        flags_ff[MEF_B_OVF]);
    c_unf:  cover property (@(posedge clk) disable iff (!rst_b)
        tx_force_mark);
    c_read: cover property (@(posedge clk) disable iff (!rst_b)
        flag_rd && flags_ff != 8'h00);

endmodule : mef_event_irq

//--- mef_pkg.sv
// Package for the modem event-flag and interrupt block
package mef_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] MEF_FLAGS_ADDR = 8'hEF;
    localparam logic [7:0] MEF_MASK_ADDR  = 8'hEE;
    localparam logic [7:0] MEF_TONES_ADDR = 8'hEC;

    // =========================================================
    // Flag bit positions
    localparam int MEF_B_PARITY = 7;
    localparam int MEF_B_RING   = 6;
    localparam int MEF_B_TONE   = 5;
    localparam int MEF_B_OVF    = 4;
    localparam int MEF_B_RXRDY  = 3;
    localparam int MEF_B_UNF    = 2;
    localparam int MEF_B_TXRDY  = 1;
    localparam int MEF_B_MARK   = 0;

    // =========================================================
    // Reset values and timing
    localparam logic [7:0] MEF_FLAGS_RST = 8'h00;
    localparam logic [7:0] MEF_MASK_RST  = 8'h00;
    localparam int MEF_CLK_HZ  = 50_000_000;
    localparam int MEF_BAUD_HZ = 1200;
    localparam int MEF_BIT_CYC = MEF_CLK_HZ / MEF_BAUD_HZ;
    localparam int MEF_WIN_BITS = 8;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic ring;
        logic call_tone_present;
        logic carrier;
        logic answer;
        logic plain_mark_present;
    } mef_status_t;

    typedef struct packed {
        logic tx_high;
        logic rx_high;
    } mef_band_t;

    typedef struct packed {
        logic tx_hi_eq;
        logic tx_lo_eq;
        logic rx_hi_eq;
        logic rx_lo_eq;
        logic bypass;
    } mef_eq_route_t;

endpackage : mef_pkg

//--- mef_bit_tick.sv
// Bit-period enable divider
`timescale 1ns/1ps
module mef_bit_tick #(
    parameter int DIV = mef_pkg::MEF_BIT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Enable out
    output logic      tick
);
    import mef_pkg::*;

    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == 16'(DIV - 1)) begin
            nxt_cnt = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_ff <= 16'h0000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign tick = (cnt_ff == 16'(DIV - 1));

endmodule : mef_bit_tick

//--- mef_window.sv
// Eight-bit-period service window timer
`timescale 1ns/1ps
module mef_window #(
    parameter int BITS = mef_pkg::MEF_WIN_BITS
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Control
    input  wire logic bit_tick,
    input  wire logic start,
    input  wire logic serviced,
    // Result
    output logic      expired
);
    import mef_pkg::*;

    logic       run_ff;
    logic [3:0] cnt_ff;
    logic       nxt_run;
    logic [3:0] nxt_cnt;

    always_comb begin
        nxt_run = run_ff;
        nxt_cnt = cnt_ff;
        expired = 1'b0;
        if (start) begin
            nxt_run = 1'b1;
            nxt_cnt = 4'h0;
        end else if (serviced) begin
            nxt_run = 1'b0;
        end else if (run_ff && bit_tick) begin
            if (cnt_ff == 4'(BITS - 1)) begin
                expired = 1'b1;
                nxt_run = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else begin
            run_ff <= nxt_run;
            cnt_ff <= nxt_cnt;
        end
    end

endmodule : mef_window

//--- mef_host_mdl.sv
// Host model that drives the register port and data strobes
`timescale 1ns/1ps
module mef_host_mdl (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Commands from the bench
    input  wire logic       cmd_rd,
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_rx_read,
    input  wire logic       cmd_tx_load,
    // Register port and data strobes
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    output logic            rx_data_read,
    output logic            tx_data_load
);
    // =========================================================
    // Strobes last one cycle; an idle bus inverts its value on every cycle, so
    // the last live address and data come back on every second idle cycle
    always @(posedge clk) begin
        reg_rd       <= rst_b & cmd_rd;
        reg_wr       <= rst_b & cmd_wr;
        rx_data_read <= rst_b & cmd_rx_read;
        tx_data_load <= rst_b & cmd_tx_load;
        if (!rst_b) begin
            reg_addr  <= 8'h00;
            reg_wdata <= 8'h00;
        end else if (cmd_rd | cmd_wr) begin
            reg_addr  <= cmd_addr;
            reg_wdata <= cmd_wdata;
        end else begin
            reg_addr  <= ~reg_addr;
            reg_wdata <= ~reg_wdata;
        end
    end
endmodule : mef_host_mdl

//--- tb_top.sv
// Self-checking bench for the event flag and interrupt block
`timescale 1ns/1ps
module tb_top;
    import mef_pkg::*;
    // Short bit period keeps the service windows at 29 to 32 cycles
    localparam int BC = 4;
    logic        clk, rst_b, rx_parity_bad, cmd_rd, cmd_wr, rd_d;
    logic [7:0]  cmd_addr, cmd_wdata, reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, rx_data_read, tx_data_load;
    logic        tx_force_mark, irq_b;
    logic [3:0]  ev;
    logic [4:0]  det;
    logic [7:0]  m;
    logic [31:0] seed;
    mef_band_t     band;
    mef_eq_route_t eq_route;
    logic [7:0]  exp_q[$];
    int          err_count, checks_done;

    mef_host_mdl host (.clk(clk), .rst_b(rst_b), .cmd_rd(cmd_rd),
        .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_rx_read(ev[1]), .cmd_tx_load(ev[0]), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .rx_data_read(rx_data_read), .tx_data_load(tx_data_load));

    mef_event_irq #(.BIT_CYC(BC), .WIN_BITS(MEF_WIN_BITS)) dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_byte_done(ev[3]), .rx_parity_bad(rx_parity_bad),
        .rx_data_read(rx_data_read), .tx_buf_free(ev[2]),
        .tx_data_load(tx_data_load), .ring_timing_node(det[4]),
        .call_tone_present(det[3]), .carrier_present(det[2]),
        .answer_present(det[1]), .plain_mark_present(det[0]),
        .channel_band_select(band), .eq_route(eq_route),
        .tx_force_mark(tx_force_mark), .irq_b(irq_b));

    // =========================================================
    // Checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Read data lands the cycle after the strobe is taken
    always @(posedge clk) begin
        if (rd_d === 1'b1)
            chk(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
    end

    // =========================================================
    // Drivers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        cmd_rd = 1'b1;
        cmd_addr = a;
        tick(1);
        cmd_rd = 1'b0;
        tick(2);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cmd_wr = 1'b1;
        cmd_addr = a;
        cmd_wdata = d;
        tick(1);
        cmd_wr = 1'b0;
        tick(2);
    endtask : wr

    task automatic pulse(input int b);
        ev[b] = 1'b1;
        tick(1);
        ev[b] = 1'b0;
        tick(2);
    endtask : pulse

    task automatic irq_is(input logic v);
        chk({7'h00, irq_b}, {7'h00, v});
    endtask : irq_is

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Whole run is about 430 cycles, so 100 us is a safe ceiling
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end

    // =========================================================
    // Scenarios
    initial begin
        {rst_b, rx_parity_bad, cmd_rd, cmd_wr, rd_d} = 5'h00;
        {cmd_addr, cmd_wdata, ev, det, m} = '0;
        band = '0;
        seed = 32'h00000041;
        err_count = 0;
        checks_done = 0;
        tick(2);
        rst_b = 1'b1;
        irq_is(1'b1);
        rd(MEF_FLAGS_ADDR, 8'h00);
        rd(MEF_MASK_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        wr(MEF_FLAGS_ADDR, 8'hFF);
        rd(MEF_FLAGS_ADDR, 8'h00);
        wr(MEF_MASK_ADDR, 8'hFF);
        // Each detector rises then falls; both edges must flag
        for (int i = 0; i < 5; i++) begin
            for (int v = 1; v >= 0; v--) begin
                det[i] = v[0];
                tick(3);
                irq_is(1'b0);
                rd(MEF_TONES_ADDR, {1'b1, det[4:1], 2'b00, det[0]});
                m = (i == 4) ? 8'h40 : (i == 0) ? 8'h01 : 8'h20;
                rd(MEF_FLAGS_ADDR, m);
                irq_is(1'b1);
            end
        end
        rx_parity_bad = 1'b1;
        pulse(3);
        rd(MEF_FLAGS_ADDR, 8'h88);
        pulse(1);
        rx_parity_bad = 1'b0;
        pulse(3);
        tick(40);
        rd(MEF_FLAGS_ADDR, 8'h18);
        pulse(3);
        tick(40);
        rd(MEF_FLAGS_ADDR, 8'h00);
        pulse(1);
        pulse(3);
        rd(MEF_FLAGS_ADDR, 8'h08);
        pulse(1);
        // Underflow only unmasked: irq must wait for the whole window
        wr(MEF_MASK_ADDR, 8'h04);
        pulse(2);
        tick(22);
        irq_is(1'b1);
        tick(16);
        irq_is(1'b0);
        chk({7'h00, tx_force_mark}, 8'h01);
        rd(MEF_FLAGS_ADDR, 8'h06);
        pulse(2);
        tick(40);
        rd(MEF_FLAGS_ADDR, 8'h00);
        pulse(0);
        chk({7'h00, tx_force_mark}, 8'h00);
        pulse(2);
        pulse(0);
        tick(40);
        rd(MEF_FLAGS_ADDR, 8'h02);
        wr(MEF_MASK_ADDR, 8'h01);
        det[4] = 1'b1;
        tick(3);
        irq_is(1'b1);
        det[0] = 1'b1;
        tick(3);
        irq_is(1'b0);
        rd(MEF_FLAGS_ADDR, 8'h41);
        {det[4], det[0]} = 2'b00;
        tick(3);
        rd(MEF_FLAGS_ADDR, 8'h41);
        for (int b = 0; b < 4; b++) begin
            band = b[1:0];
            m = 8'(xs());
            wr(MEF_MASK_ADDR, m);
            chk({7'h00, eq_route.bypass}, {7'h00, b[1] == b[0]});
            if (b[1] != b[0])
                chk(8'(eq_route[4:1]), (b == 1) ? 8'h06 : 8'h09);
            rd(MEF_MASK_ADDR, m);
        end
        // Reset in mid-run with a flag pending
        wr(MEF_MASK_ADDR, 8'hFF);
        det[0] = 1'b1;
        tick(3);
        det[0] = 1'b0;
        rst_b = 1'b0;
        tick(2);
        irq_is(1'b1);
        rst_b = 1'b1;
        rd(MEF_FLAGS_ADDR, 8'h00);
        rd(MEF_MASK_ADDR, 8'h00);
        tick(2);
        report_and_stop();
    end
endmodule : tb_top
